// ==== shared/crs_pkg.sv ====
// ----------------------------------------------------------------
// Serial configuration slave constants
// ----------------------------------------------------------------
package crs_pkg;
    // Device address after programming (default value)
    localparam logic [6:0] DEV_ADDR_DEF = 7'h69;
    // Address windows that hold configuration state
    localparam logic [7:0] CFG_LO_A = 8'h08;
    localparam logic [7:0] CFG_HI_A = 8'h1b;
    localparam logic [7:0] CFG_LO_B = 8'h40;
    localparam logic [7:0] CFG_HI_B = 8'h57;
    // Values after reset
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] BIT_RST = 4'h0;
    // Bit count at which the acknowledge slot starts
    localparam logic [3:0] BIT_ACK = 4'h8;
    // Pointer step
    localparam logic [7:0] PTR_STEP = 8'h01;
    // Register space depth
    localparam int MEM_DEPTH = 256;

    typedef enum logic [4:0] {
        CRS_IDLE = 5'h01,
        CRS_DEV = 5'h02,
        CRS_REG = 5'h04,
        CRS_WDAT = 5'h08,
        CRS_RDAT = 5'h10
    } crs_state_type;
endpackage

// ==== src/crs_serial_slave.sv ====
// Operation
// - Register address follows write device address, acked
// - Written data byte acknowledged low unless previous word still pending, else released and idle
// - Burst bytes stored if in a mapped window, address advanced each
// - Direction bit one selects read
// - Pointer holds last accessed address plus one
// - Read address acked, byte at pointer sent
// - Unacked read byte ends transmission, release
// - Repeated START loads pointer, stores nothing
// - Pointer advances after each byte sent, master ack sends next
// - Unmapped addresses read as zero, no error
// - Pointer wraps from FFH to 00H
// - Seven bit address plus direction bit
// - Ack drives data low in ninth clock
// - START, STOP detected while clock high
`timescale 1ns/1ps
module crs_serial_slave #(
    parameter logic [6:0] DEV_ADDR = crs_pkg::DEV_ADDR_DEF
) (
    // Core clock and reset
    input wire logic CLK_I,
    input wire logic SRST_I,
    // Link sampling clock
    input wire logic LINK_CLK_I,
    // Serial bus pins
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    // Configuration write stream
    output logic CFG_VALID_O,
    output logic [7:0] CFG_ADDR_O,
    output logic [7:0] CFG_DATA_O,
    input wire logic CFG_READY_I
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic in_cfg(input logic [7:0] a);
        in_cfg = (a >= crs_pkg::CFG_LO_A && a <= crs_pkg::CFG_HI_A) ||
                 (a >= crs_pkg::CFG_LO_B && a <= crs_pkg::CFG_HI_B);
    endfunction

    // ------------------------------------------------------------
    // Link side synchronisers
    // ------------------------------------------------------------
    logic lrst_s1, lrst;
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic ak_s1, ak_s2;
    logic req_tgl, ack_tgl;

    always_ff @(posedge LINK_CLK_I) begin
        lrst_s1 <= SRST_I;
        lrst <= lrst_s1;
    end

    always_ff @(posedge LINK_CLK_I) begin
        if (lrst) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
            ak_s1 <= 1'b0;
            ak_s2 <= 1'b0;
        end else begin
            scl_s1 <= SCL_I;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= SDA_I;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
            ak_s1 <= ack_tgl;
            ak_s2 <= ak_s1;
        end
    end

    // ------------------------------------------------------------
    // Bus events
    // ------------------------------------------------------------
    crs_pkg::crs_state_type st;
    logic [3:0] bitcnt;
    logic ackph, rw, mack, sda_oe, busy;
    logic [7:0] sh, ptr, rd_byte, xw_addr, xw_data;
    logic [7:0] mem [crs_pkg::MEM_DEPTH];
    logic scl_rise, scl_fall, start_c, stop_c, dec, ack_end;
    logic match, wr_now, load_rd;

    assign scl_rise = scl_s2 && !scl_s3;
    assign scl_fall = !scl_s2 && scl_s3;
    assign start_c = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
    assign stop_c = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
    assign dec = scl_fall && !ackph && bitcnt == crs_pkg::BIT_ACK;
    assign ack_end = scl_fall && ackph;
    assign match = sh[7:1] == DEV_ADDR;
    assign busy = req_tgl != ak_s2;
    assign wr_now = dec && st == crs_pkg::CRS_WDAT && !busy &&
                    in_cfg(ptr);
    assign rd_byte = in_cfg(ptr) ? mem[ptr] : crs_pkg::BYTE_RST;
    assign load_rd = ack_end && ((st == crs_pkg::CRS_DEV && rw) ||
                     (st == crs_pkg::CRS_RDAT && mack));

    // ------------------------------------------------------------
    // Protocol control
    // ------------------------------------------------------------
    always_ff @(posedge LINK_CLK_I) begin
        if (lrst) begin
            st <= crs_pkg::CRS_IDLE;
            bitcnt <= crs_pkg::BIT_RST;
            ackph <= 1'b0;
            rw <= 1'b0;
            mack <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start_c) begin
            st <= crs_pkg::CRS_DEV;
            bitcnt <= crs_pkg::BIT_RST;
            ackph <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_c) begin
            st <= crs_pkg::CRS_IDLE;
            ackph <= 1'b0;
            sda_oe <= 1'b0;
        end else if (st != crs_pkg::CRS_IDLE) begin
            if (scl_rise) begin
                if (!ackph && bitcnt != crs_pkg::BIT_ACK) begin
                    bitcnt <= 4'(bitcnt + 4'h1);
                end
                if (ackph) begin
                    mack <= !sda_s2;
                end
            end
            if (ack_end) begin
                ackph <= 1'b0;
                bitcnt <= crs_pkg::BIT_RST;
                sda_oe <= 1'b0;
                unique case (st)
                    crs_pkg::CRS_IDLE: st <= crs_pkg::CRS_IDLE;
                    crs_pkg::CRS_DEV: begin
                        if (rw) begin
                            st <= crs_pkg::CRS_RDAT;
                            sda_oe <= !rd_byte[7];
                        end else begin
                            st <= crs_pkg::CRS_REG;
                        end
                    end
                    crs_pkg::CRS_REG: st <= crs_pkg::CRS_WDAT;
                    crs_pkg::CRS_WDAT: st <= crs_pkg::CRS_WDAT;
                    crs_pkg::CRS_RDAT: begin
                        if (mack) begin
                            sda_oe <= !rd_byte[7];
                        end else begin
                            st <= crs_pkg::CRS_IDLE;
                        end
                    end
                endcase
            end else if (dec) begin
                unique case (st)
                    crs_pkg::CRS_IDLE: st <= crs_pkg::CRS_IDLE;
                    crs_pkg::CRS_DEV: begin
                        if (match) begin
                            ackph <= 1'b1;
                            sda_oe <= 1'b1;
                            rw <= sh[0];
                        end else begin
                            st <= crs_pkg::CRS_IDLE;
                        end
                    end
                    crs_pkg::CRS_REG: begin
                        ackph <= 1'b1;
                        sda_oe <= 1'b1;
                    end
                    crs_pkg::CRS_WDAT: begin
                        if (busy) begin
                            st <= crs_pkg::CRS_IDLE;
                        end else begin
                            ackph <= 1'b1;
                            sda_oe <= 1'b1;
                        end
                    end
                    crs_pkg::CRS_RDAT: begin
                        ackph <= 1'b1;
                        sda_oe <= 1'b0;
                    end
                endcase
            end else if (scl_fall && st == crs_pkg::CRS_RDAT) begin
                sda_oe <= !sh[7];
            end
        end
    end

    // ------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------
    always_ff @(posedge LINK_CLK_I) begin
        if (lrst) begin
            sh <= crs_pkg::BYTE_RST;
        end else if (load_rd) begin
            sh <= rd_byte;
        end else if (scl_rise && !ackph && bitcnt != crs_pkg::BIT_ACK) begin
            sh <= {sh[6:0], sda_s2};
        end
    end

    // ------------------------------------------------------------
    // Address pointer
    // ------------------------------------------------------------
    always_ff @(posedge LINK_CLK_I) begin
        if (lrst) begin
            ptr <= crs_pkg::PTR_RST;
        end else if (dec && st == crs_pkg::CRS_REG) begin
            ptr <= sh;
        end else if (dec && ((st == crs_pkg::CRS_WDAT && !busy) ||
                     st == crs_pkg::CRS_RDAT)) begin
            ptr <= 8'(ptr + crs_pkg::PTR_STEP);
        end
    end

    // ------------------------------------------------------------
    // Register space
    // ------------------------------------------------------------
    always_ff @(posedge LINK_CLK_I) begin
        if (lrst) begin
            for (int i = 0; i < crs_pkg::MEM_DEPTH; i++) begin
                mem[i] <= crs_pkg::BYTE_RST;
            end
        end else if (wr_now) begin
            mem[ptr] <= sh;
        end
    end

    // ------------------------------------------------------------
    // Write word toward core
    // ------------------------------------------------------------
    always_ff @(posedge LINK_CLK_I) begin
        if (lrst) begin
            req_tgl <= 1'b0;
            xw_addr <= crs_pkg::BYTE_RST;
            xw_data <= crs_pkg::BYTE_RST;
        end else if (wr_now) begin
            req_tgl <= !req_tgl;
            xw_addr <= ptr;
            xw_data <= sh;
        end
    end

    assign SDA_O = 1'b0;
    assign SDA_OE_O = sda_oe;

    // ------------------------------------------------------------
    // Core side crossing and two-entry buffer
    // ------------------------------------------------------------
    logic rq_s1, rq_s2, push, pop, sp_valid;
    logic [7:0] sp_addr, sp_data;

    assign push = (rq_s2 != ack_tgl) && !sp_valid;
    assign pop = CFG_VALID_O && CFG_READY_I;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rq_s1 <= 1'b0;
            rq_s2 <= 1'b0;
            ack_tgl <= 1'b0;
        end else begin
            rq_s1 <= req_tgl;
            rq_s2 <= rq_s1;
            if (push) begin
                ack_tgl <= !ack_tgl;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            CFG_VALID_O <= 1'b0;
            CFG_ADDR_O <= crs_pkg::BYTE_RST;
            CFG_DATA_O <= crs_pkg::BYTE_RST;
            sp_valid <= 1'b0;
            sp_addr <= crs_pkg::BYTE_RST;
            sp_data <= crs_pkg::BYTE_RST;
        end else if (pop && sp_valid) begin
            CFG_ADDR_O <= sp_addr;
            CFG_DATA_O <= sp_data;
            sp_valid <= 1'b0;
        end else if (push && (!CFG_VALID_O || pop)) begin
            CFG_VALID_O <= 1'b1;
            CFG_ADDR_O <= xw_addr;
            CFG_DATA_O <= xw_data;
        end else if (push) begin
            sp_valid <= 1'b1;
            sp_addr <= xw_addr;
            sp_data <= xw_data;
        end else if (pop) begin
            CFG_VALID_O <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_nack_foreign: assert property (@(posedge LINK_CLK_I) disable iff (lrst)
        dec && st == crs_pkg::CRS_DEV && !match && !start_c && !stop_c
        |=> !sda_oe && st == crs_pkg::CRS_IDLE)
        else $error("foreign address acknowledged");
    a_ack_low: assert property (@(posedge LINK_CLK_I) disable iff (lrst)
        ackph && st != crs_pkg::CRS_RDAT |-> sda_oe)
        else $error("ack slot not driven low");
    a_reg_load: assert property (@(posedge LINK_CLK_I) disable iff (lrst)
        dec && st == crs_pkg::CRS_REG && !start_c && !stop_c
        |=> ptr == $past(sh))
        else $error("pointer not loaded");
    a_ptr_step: assert property (@(posedge LINK_CLK_I) disable iff (lrst)
        dec && st == crs_pkg::CRS_WDAT && !busy && !start_c && !stop_c
        |=> ptr == 8'($past(ptr) + 8'h01))
        else $error("pointer not advanced");
    a_ptr_wrap: assert property (@(posedge LINK_CLK_I) disable iff (lrst)
        dec && st == crs_pkg::CRS_RDAT && ptr == 8'hff && !start_c && !stop_c
        |=> ptr == 8'h00)
        else $error("pointer did not wrap");
    a_store_byte: assert property (@(posedge LINK_CLK_I) disable iff (lrst)
        wr_now && !start_c && !stop_c
        |=> mem[$past(ptr)] == $past(sh) && req_tgl != $past(req_tgl))
        else $error("byte not stored");
    a_oor_quiet: assert property (@(posedge LINK_CLK_I) disable iff (lrst)
        dec && st == crs_pkg::CRS_WDAT && !in_cfg(ptr)
        |=> $stable(req_tgl))
        else $error("unmapped write sent");
    a_stop_free: assert property (@(posedge LINK_CLK_I) disable iff (lrst)
        stop_c |=> !sda_oe && st == crs_pkg::CRS_IDLE)
        else $error("line held after stop");
    a_start_dev: assert property (@(posedge LINK_CLK_I) disable iff (lrst)
        start_c |=> st == crs_pkg::CRS_DEV && bitcnt == 4'h0)
        else $error("start not seen");
    a_rd_bit: assert property (@(posedge LINK_CLK_I) disable iff (lrst)
        scl_fall && st == crs_pkg::CRS_RDAT && !ackph &&
        bitcnt != crs_pkg::BIT_ACK && !start_c && !stop_c
        |=> sda_oe == !$past(sh[7]))
        else $error("read bit wrong");
    a_rd_next: assert property (@(posedge LINK_CLK_I) disable iff (lrst)
        load_rd && !start_c && !stop_c
        |=> sh == $past(rd_byte) && sda_oe == !$past(rd_byte[7]))
        else $error("next read byte wrong");
    a_buf_hold: assert property (@(posedge CLK_I) disable iff (SRST_I)
        CFG_VALID_O && !CFG_READY_I
        |=> CFG_VALID_O && $stable(CFG_ADDR_O) && $stable(CFG_DATA_O))
        else $error("stalled word lost");

    c_write: cover property (@(posedge LINK_CLK_I) disable iff (lrst)
        wr_now);
    c_seq_read: cover property (@(posedge LINK_CLK_I) disable iff (lrst)
        load_rd && st == crs_pkg::CRS_RDAT);
    c_nack: cover property (@(posedge LINK_CLK_I) disable iff (lrst)
        dec && st == crs_pkg::CRS_DEV && !match);
    c_buf_full: cover property (@(posedge CLK_I) disable iff (SRST_I)
        sp_valid && CFG_VALID_O && !CFG_READY_I);
endmodule

// ==== test/crs_bus_master.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-wire bus master model, open drain data, pull-up on the wire
// ----------------------------------------------------------------
module crs_bus_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    localparam int HALF = 13;

    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic wait_half();
        repeat (HALF) @(negedge clk_i);
    endtask

    // Data set with clock low, sampled at the end of clock high
    task automatic bit_cycle(input logic b, output logic s);
        sda_oe_o = ~b;
        wait_half();
        scl_o = 1'b1;
        wait_half();
        s = sda_i;
        scl_o = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask

    task automatic start();
        sda_oe_o = 1'b0;
        wait_half();
        scl_o = 1'b1;
        wait_half();
        sda_oe_o = 1'b1;
        wait_half();
        scl_o = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask

    task automatic stop();
        sda_oe_o = 1'b1;
        wait_half();
        scl_o = 1'b1;
        wait_half();
        sda_oe_o = 1'b0;
        wait_half();
    endtask

    // MSB first, ninth cycle released for the slave
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(d[i], s);
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask

    task automatic rd_byte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            d[i] = s;
        end
        bit_cycle(~more, s);
    endtask
endmodule

// ==== test/config_register_serial_slave_tb.sv ====
`timescale 1ns/1ps
module config_register_serial_slave_tb;
    logic clk, link_clk, srst, ready, scl, m_oe, dut_o, dut_oe;
    logic cfg_valid, oe_seen;
    logic [7:0] cfg_addr, cfg_data, d;
    wire logic sda;
    int err_count = 0;
    int comparisons = 0;
    logic [15:0] words[$];
    localparam logic [7:0] WR = {crs_pkg::DEV_ADDR_DEF, 1'b0};
    localparam logic [7:0] RD = {crs_pkg::DEV_ADDR_DEF, 1'b1};

    assign sda = ~(m_oe | (dut_oe & ~dut_o));

    crs_serial_slave dut (.CLK_I(clk), .SRST_I(srst), .LINK_CLK_I(link_clk),
        .SCL_I(scl), .SDA_I(sda), .SDA_O(dut_o), .SDA_OE_O(dut_oe),
        .CFG_VALID_O(cfg_valid), .CFG_ADDR_O(cfg_addr),
        .CFG_DATA_O(cfg_data), .CFG_READY_I(ready));
    crs_bus_master m (.clk_i(clk), .sda_i(sda), .scl_o(scl),
        .sda_oe_o(m_oe));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #3.7;
        forever #7.5 link_clk = ~link_clk;
    end
    always @(posedge clk) if (!srst && cfg_valid === 1'b1 && ready)
        words.push_back({cfg_addr, cfg_data});
    always @(posedge link_clk) if (dut_oe === 1'b1) oe_seen <= 1'b1;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp,
            input logic [15:0] seen);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr_regs(input logic [7:0] ra, input int n,
            input logic [7:0] d0, input logic last_ack);
        logic a;
        m.start();
        m.wr_byte(WR, a);
        check("addr ack", 16'(1), 16'(a));
        m.wr_byte(ra, a);
        check("reg ack", 16'(1), 16'(a));
        for (int i = 0; i < n; i++) begin
            m.wr_byte(d0 + 8'(8'h11 * i), a);
            check("data ack", 16'(i == n - 1 ? last_ack : 1'b1), 16'(a));
        end
        m.stop();
    endtask

    task automatic read_at(input logic [7:0] ra);
        logic a;
        m.start();
        m.wr_byte(WR, a);
        m.wr_byte(ra, a);
        m.start();
        m.wr_byte(RD, a);
        check("read addr ack", 16'(1), 16'(a));
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_foreign();
        logic a;
        oe_seen = 1'b0;
        m.start();
        m.wr_byte(WR ^ 8'h02, a);
        check("foreign ack", 16'(0), 16'(a));
        m.wr_byte(8'h10, a);
        m.stop();
        check("foreign drive", 16'(0), 16'(oe_seen));
        $display("test foreign done");
    endtask

    task automatic t_stall();
        ready = 1'b0;
        wr_regs(8'h1a, 3, 8'ha1, 1'b1);
        check("held words", 16'(0), 16'(words.size()));
        ready = 1'b1;
        repeat (20) @(negedge clk);
        check("word count", 16'(2), 16'(words.size()));
        check("word 0", 16'h1aa1, words[0]);
        check("word 1", 16'h1bb2, words[1]);
        $display("test stall done");
    endtask

    task automatic t_seq_read();
        read_at(8'h1a);
        m.rd_byte(1'b1, d);
        check("read 1a", 16'(8'ha1), 16'(d));
        m.rd_byte(1'b1, d);
        check("read 1b", 16'(8'hb2), 16'(d));
        m.rd_byte(1'b0, d);
        check("read 1c", 16'(0), 16'(d));
        m.stop();
        repeat (10) @(negedge clk);
        check("released", 16'(0), 16'(dut_oe));
        check("no store", 16'(2), 16'(words.size()));
        $display("test sequential read done");
    endtask

    task automatic t_current();
        logic a;
        wr_regs(8'h16, 2, 8'h5a, 1'b1);
        repeat (20) @(negedge clk);
        check("burst word", 16'h176b, words[3]);
        read_at(8'h16);
        m.rd_byte(1'b0, d);
        m.stop();
        m.start();
        m.wr_byte(RD, a);
        m.rd_byte(1'b0, d);
        m.stop();
        check("current read", 16'(8'h6b), 16'(d));
        $display("test current read done");
    endtask

    task automatic t_wrap();
        wr_regs(8'hfe, 11, 8'h90, 1'b1);
        repeat (20) @(negedge clk);
        check("wrap count", 16'(5), 16'(words.size()));
        check("wrap word", {8'h08, 8'h90 + 8'(8'h11 * 10)}, words[4]);
        $display("test wrap done");
    endtask

    initial begin
        srst = 1'b1;
        ready = 1'b1;
        oe_seen = 1'b0;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        repeat (10) @(negedge clk);
        check("idle drive", 16'(0), 16'(dut_oe));
        check("idle valid", 16'(0), 16'(cfg_valid));
        t_foreign();
        t_stall();
        t_seq_read();
        t_current();
        t_wrap();
        summarize();
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        summarize();
    end
endmodule
